// ### filter_datapath_model.sv
// Behavioural datapath side that feeds branch conditions
`timescale 1ns/1ns
`default_nettype none
module filter_datapath_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] cond_req,
    output logic [7:0] branch_conditions
);
    // Flags settle one cycle after the bench asks for them
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            branch_conditions <= 8'h00;
        else
            branch_conditions <= cond_req;
endmodule : filter_datapath_model
`default_nettype wire

// ### filter_microsequencer.sv
// Microcoded sequencer of the filter engine with APB register access
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "filter_seq_params.svh"
module filter_microsequencer #(
    parameter int COND_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [COND_W-1:0] branch_conditions,
    output logic [17:0] datapath_control_bus,
    output logic bus_write_strobe,
    output logic [3:0] addr_unit_a_opcode,
    output logic [3:0] addr_unit_b_opcode,
    output logic [3:0] addr_unit_ram_addr,
    output logic end_of_block
);
    logic [31:0] engine_control_reg;
    logic run;
    logic state_bank_select;
    logic [4:0] state_addr;
    logic [5:0] pc0;
    logic [5:0] pc1;
    logic [5:0] loop_start;
    filter_seq_pkg::cs_sel_t active_ram;
    filter_seq_pkg::seq_phase_t phase;
    logic [31:0] state_word;
    logic [31:0] cs0_word;
    logic [31:0] cs1_word;
    logic [31:0] ctrl_word;
    logic apb_access;
    logic apb_wr;
    logic apb_rd_ack;
    logic [5:0] ram_waddr;
    logic we_state;
    logic we_cs0;
    logic we_cs1;
    logic bad_addr;
    logic cond_true;
    logic eob;
    logic loop_flag;
    logic [5:0] jaddr;
    logic [5:0] limit;
    logic [5:0] faddr;
    logic [4:0] nstate;
    logic [5:0] cur_pc;
    logic [5:0] next_pc0;
    logic [5:0] next_pc1;
    logic [4:0] next_state_addr;
    filter_seq_pkg::cs_sel_t next_active;
    logic [5:0] next_loop_start;
    logic [31:0] next_prdata;

    function automatic logic [5:0] inc_wrap(input logic [5:0] pc, input logic [5:0] lim,
                                            input logic [5:0] start);
        if (pc == lim)
        begin
            inc_wrap = start;
        end
        else
        begin
            inc_wrap = pc + 6'h01;
        end
    endfunction : inc_wrap

    function automatic logic in_window(input logic [11:0] a, input logic [11:0] base);
        in_window = (a[11:8] == base[11:8]) && (a[1:0] == 2'h0);
    endfunction : in_window

    assign run = engine_control_reg[`FS_CTRL_RUN];
    assign state_bank_select = engine_control_reg[`FS_CTRL_BANK];
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite && !pready;
    assign ram_waddr = paddr[7:2];

    // RAM loads only while stopped; write refused otherwise
    assign we_state = apb_wr && !run && in_window(paddr, `FS_WIN_STATE);
    assign we_cs0 = apb_wr && !run && in_window(paddr, `FS_WIN_CS0);
    assign we_cs1 = apb_wr && !run && in_window(paddr, `FS_WIN_CS1);

    always_comb
    begin
        bad_addr = 1'b1;
        if (paddr == `FS_REG_CTRL || paddr == `FS_REG_STATUS || paddr == `FS_REG_STATE_ADDR
            || paddr == `FS_REG_PC)
        begin
            bad_addr = 1'b0;
        end
        else if (in_window(paddr, `FS_WIN_STATE) || in_window(paddr, `FS_WIN_CS0)
                 || in_window(paddr, `FS_WIN_CS1))
        begin
            bad_addr = pwrite ? run : 1'b1;
        end
    end

    // State RAM: bank bit is the top address bit
    filter_seq_ram #(.WIDTH(32), .DEPTH(64), .AW(6)) u_state_ram (
        .pclk(pclk),
        .we(we_state),
        .waddr(ram_waddr),
        .wdata(pwdata),
        .raddr({state_bank_select, next_state_addr}),
        .rdata(state_word)
    );

    // Each control-store RAM has its own counter so branch targets can differ
    filter_seq_ram #(.WIDTH(32), .DEPTH(64), .AW(6)) u_cs_ram0 (
        .pclk(pclk),
        .we(we_cs0),
        .waddr(ram_waddr),
        .wdata(pwdata),
        .raddr(next_pc0),
        .rdata(cs0_word)
    );

    filter_seq_ram #(.WIDTH(32), .DEPTH(64), .AW(6)) u_cs_ram1 (
        .pclk(pclk),
        .we(we_cs1),
        .waddr(ram_waddr),
        .wdata(pwdata),
        .raddr(next_pc1),
        .rdata(cs1_word)
    );

    // State word decode
    assign loop_flag = state_word[`FS_ST_LOOP];
    assign jaddr = state_word[`FS_ST_JADDR_HI:`FS_ST_JADDR_LO];
    assign limit = state_word[`FS_ST_LIMIT_HI:`FS_ST_LIMIT_LO];
    assign faddr = state_word[`FS_ST_FADDR_HI:`FS_ST_FADDR_LO];
    assign nstate = state_word[`FS_ST_NEXT_HI:`FS_ST_NEXT_LO];
    // Flag masks qualify the branch conditions
    assign cond_true = |(state_word[`FS_ST_ENABLES_HI:`FS_ST_ENABLES_LO] & branch_conditions[7:0]);

    // Active control word
    assign ctrl_word = (active_ram == filter_seq_pkg::cs_ram1) ? cs1_word : cs0_word;
    assign eob = ctrl_word[`FS_CW_EOB];
    assign cur_pc = (active_ram == filter_seq_pkg::cs_ram1) ? pc1 : pc0;

    // Next-state and program counter decision
    always_comb
    begin
        next_state_addr = state_addr;
        next_pc0 = pc0;
        next_pc1 = pc1;
        next_active = active_ram;
        next_loop_start = loop_start;
        if (!run || phase != filter_seq_pkg::seq_exec)
        begin
            next_state_addr = 5'h00;
            next_pc0 = 6'h00;
            next_pc1 = 6'h00;
            next_active = filter_seq_pkg::cs_ram0;
            next_loop_start = 6'h00;
        end
        else if (eob && cond_true)
        begin
            // Jump on true: RAM 0 gets the true target, RAM 1 the false one
            next_state_addr = nstate;
            next_pc0 = jaddr;
            next_pc1 = faddr;
            next_active = filter_seq_pkg::cs_ram0;
            next_loop_start = jaddr;
        end
        else if (eob && !loop_flag)
        begin
            // Flow through on false: false target from RAM 1
            next_state_addr = nstate;
            next_pc0 = jaddr;
            next_pc1 = faddr;
            next_active = filter_seq_pkg::cs_ram1;
            next_loop_start = faddr;
        end
        else if (eob && loop_flag)
        begin
            // Loop state on false: back to the false address, same state
            next_pc0 = faddr;
            next_pc1 = faddr;
            next_loop_start = faddr;
        end
        else
        begin
            // Sequential fetch with wrap at the loop limit
            next_pc0 = inc_wrap(cur_pc, limit, loop_start);
            next_pc1 = inc_wrap(cur_pc, limit, loop_start);
        end
    end

    // Start-up: one fetch cycle so RAM outputs are valid before execution
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= filter_seq_pkg::seq_idle;
        end
        else
        begin
            case (phase)
                filter_seq_pkg::seq_idle:
                    phase <= run ? filter_seq_pkg::seq_fetch : filter_seq_pkg::seq_idle;
                filter_seq_pkg::seq_fetch:
                    phase <= run ? filter_seq_pkg::seq_exec : filter_seq_pkg::seq_idle;
                filter_seq_pkg::seq_exec:
                    phase <= run ? filter_seq_pkg::seq_exec : filter_seq_pkg::seq_idle;
                default:
                    phase <= filter_seq_pkg::seq_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_addr <= 5'h00;
            pc0 <= 6'h00;
            pc1 <= 6'h00;
            active_ram <= filter_seq_pkg::cs_ram0;
            loop_start <= 6'h00;
        end
        else
        begin
            state_addr <= next_state_addr;
            pc0 <= next_pc0;
            pc1 <= next_pc1;
            active_ram <= next_active;
            loop_start <= next_loop_start;
        end
    end

    // Control word fields to datapath and address units
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            datapath_control_bus <= 18'h00000;
            bus_write_strobe <= 1'b0;
            addr_unit_a_opcode <= 4'h0;
            addr_unit_b_opcode <= 4'h0;
            addr_unit_ram_addr <= 4'h0;
            end_of_block <= 1'b0;
        end
        else if (!run || phase != filter_seq_pkg::seq_exec)
        begin
            datapath_control_bus <= 18'h00000;
            bus_write_strobe <= 1'b0;
            addr_unit_a_opcode <= 4'h0;
            addr_unit_b_opcode <= 4'h0;
            addr_unit_ram_addr <= 4'h0;
            end_of_block <= 1'b0;
        end
        else
        begin
            datapath_control_bus <= ctrl_word[`FS_CW_DP_HI:`FS_CW_DP_LO];
            bus_write_strobe <= ctrl_word[`FS_CW_BUSWR];
            addr_unit_a_opcode <= ctrl_word[`FS_CW_A_HI:`FS_CW_A_LO];
            addr_unit_b_opcode <= ctrl_word[`FS_CW_B_HI:`FS_CW_B_LO];
            addr_unit_ram_addr <= ctrl_word[`FS_CW_ADDR_HI:`FS_CW_ADDR_LO];
            end_of_block <= eob;
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            engine_control_reg <= `FS_CTRL_RESET;
        end
        else if (apb_wr && paddr == `FS_REG_CTRL)
        begin
            engine_control_reg <= {30'h0, pwdata[`FS_CTRL_BANK], pwdata[`FS_CTRL_RUN]};
        end
    end

    // APB answer: one wait state, pready pulses for one cycle
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `FS_REG_CTRL: next_prdata = engine_control_reg;
            `FS_REG_STATUS: next_prdata = {29'h0, phase == filter_seq_pkg::seq_exec, run,
                                           active_ram == filter_seq_pkg::cs_ram1};
            `FS_REG_STATE_ADDR: next_prdata = {26'h0, state_bank_select, state_addr};
            `FS_REG_PC: next_prdata = {26'h0, cur_pc};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    assign apb_rd_ack = apb_access && !pwrite && !pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_access && !pready;
            pslverr <= apb_access && !pready && bad_addr;
            prdata <= apb_rd_ack ? next_prdata : 32'h0000_0000;
        end
    end
endmodule : filter_microsequencer
`default_nettype wire

// ### filter_microsequencer_test.sv
// Self-checking bench of the filter microsequencer
`timescale 1ns/1ns
`default_nettype none
module filter_microsequencer_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bws, eob, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, obs, cs0 [0:4], cs1 [0:4];
    logic [7:0] cond_req, conds;
    logic [17:0] dcb;
    logic [3:0] ua, ub, ur;
    int err_count = 0, n_checks = 0, cyc = 0, seed, k, i;
    assign obs = {dcb, bws, ua, ub, ur, eob};
    filter_microsequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .branch_conditions(conds), .datapath_control_bus(dcb), .bus_write_strobe(bws),
        .addr_unit_a_opcode(ua), .addr_unit_b_opcode(ub), .addr_unit_ram_addr(ur), .end_of_block(eob));
    filter_datapath_model i_dp (.pclk(pclk), .presetn(presetn), .cond_req(cond_req), .branch_conditions(conds));
    task stop_test;
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_word(input logic [31:0] w, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (obs !== w && n < lim);
        chk(obs, w);
    endtask : wait_word
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        seed = 87;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cond_req = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(obs, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h400, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk({rd[31:1], e}, 32'h1);
        for (i = 0; i < 64; i++)
        begin
            apb(1'b1, 12'(12'h100 + 4 * i), 32'h0);
            apb(1'b1, 12'(12'h200 + 4 * i), 32'h0);
            apb(1'b1, 12'(12'h300 + 4 * i), 32'h0);
        end
        for (k = 0; k < 2; k++)
        begin
            apb(1'b1, 12'(12'h100 + 128 * k), {8'h01, 1'b0, 6'd8, 6'd63, 6'd16, 5'd1});
            for (i = 0; i < 5; i++)
            begin
                cs0[i] = $random(seed) & 32'hffff_fffe | (i == 3);
                cs1[i] = $random(seed) & 32'hffff_fffe | (i == 3);
                apb(1'b1, 12'(12'h200 + 4 * ((i < 4) ? i : 8)), cs0[i]);
                apb(1'b1, 12'(12'h300 + 4 * ((i < 4) ? i : 16)), cs1[i]);
            end
            cond_req <= {7'($random(seed)), ~k[0]};
            apb(1'b1, 12'h000, {30'h0, k[0], 1'b1});
            wait_word(cs0[0], 8);
            wait_word(cs0[1], 3);
            wait_word(cs0[2], 1);
            wait_word(cs0[3], 1);
            wait_word(k ? cs1[4] : cs0[4], 4);
            apb(1'b0, 12'h004, 32'h0);
            chk({31'h0, rd[0]}, 32'(k));
            apb(1'b1, 12'h104, 32'h0);
            chk({31'h0, e}, 32'h1);
            apb(1'b1, 12'h000, 32'h0);
            repeat (3) @(posedge pclk);
            chk(obs, 32'h0);
            apb(1'b0, 12'h00c, 32'h0);
            chk(rd, 32'h0);
        end
        // Loop state: a false end of block goes back to the false address, state unchanged
        apb(1'b1, 12'h100, {8'h01, 1'b1, 6'd8, 6'd63, 6'd1, 5'd1});
        cond_req <= 8'h00;
        for (i = 0; i < 3; i++)
        begin
            cs0[i] = $random(seed) & 32'hffff_fffe | (i == 2);
            apb(1'b1, 12'(12'h200 + 4 * i), cs0[i]);
        end
        apb(1'b1, 12'h000, 32'h1);
        wait_word(cs0[0], 8);
        wait_word(cs0[1], 1);
        wait_word(cs0[2], 1);
        wait_word(cs0[1], 1);
        wait_word(cs0[2], 1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        repeat (3) @(posedge pclk);
        chk(obs, 32'h0);
        stop_test();
    end
endmodule : filter_microsequencer_test
`default_nettype wire

// ### filter_seq_checker.sv
// Port checker of the filter microsequencer, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module filter_seq_checker #(
    parameter int COND_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [COND_W-1:0] branch_conditions,
    input wire logic [17:0] datapath_control_bus,
    input wire logic bus_write_strobe,
    input wire logic [3:0] addr_unit_a_opcode,
    input wire logic [3:0] addr_unit_b_opcode,
    input wire logic [3:0] addr_unit_ram_addr,
    input wire logic end_of_block
);
    logic run_q;
    logic [1:0] stop_cnt;
    logic [31:0] word;
    assign word = {datapath_control_bus, bus_write_strobe, addr_unit_a_opcode, addr_unit_b_opcode,
        addr_unit_ram_addr, end_of_block};
    // Mirror of the run bit as seen by completed control writes
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            run_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 12'h000)
            run_q <= pwdata[0];
    // Cycles since the engine was stopped, saturating
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            stop_cnt <= 2'd3;
        else if (run_q)
            stop_cnt <= 2'd0;
        else if (stop_cnt != 2'd3)
            stop_cnt <= stop_cnt + 2'd1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_late_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_qual_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
    unmapped_err_a: assert property (pready && paddr[11:10] != 2'b00 |-> pslverr)
        else $error("unmapped access without error");
    ram_read_err_a: assert property (pready && !pwrite && paddr[11:8] != 4'h0 |-> pslverr && prdata == 32'h0)
        else $error("memory read not refused");
    run_load_err_a: assert property (pready && pwrite && paddr[11:8] != 4'h0 && run_q |-> pslverr)
        else $error("memory load while running not refused");
    stop_quiet_a: assert property (stop_cnt == 2'd3 |-> word == 32'h0)
        else $error("activity while stopped");
    run_echo_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[1] == run_q)
        else $error("status run bit wrong");
    cover property (pready && pslverr);
    cover property (bus_write_strobe && run_q);
    cover property (end_of_block && |branch_conditions);
endmodule : filter_seq_checker
bind filter_microsequencer filter_seq_checker #(.COND_W(COND_W)) u_seq_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .branch_conditions(branch_conditions),
    .datapath_control_bus(datapath_control_bus), .bus_write_strobe(bus_write_strobe),
    .addr_unit_a_opcode(addr_unit_a_opcode), .addr_unit_b_opcode(addr_unit_b_opcode),
    .addr_unit_ram_addr(addr_unit_ram_addr), .end_of_block(end_of_block));
`default_nettype wire

// ### filter_seq_params.svh
// Constants of the filter microsequencer
`ifndef FILTER_SEQ_PARAMS_SVH
`define FILTER_SEQ_PARAMS_SVH
`define FS_REG_CTRL 12'h000
`define FS_REG_STATUS 12'h004
`define FS_REG_STATE_ADDR 12'h008
`define FS_REG_PC 12'h00c
`define FS_WIN_STATE 12'h100
`define FS_WIN_CS0 12'h200
`define FS_WIN_CS1 12'h300
`define FS_CTRL_RUN 0
`define FS_CTRL_BANK 1
`define FS_CTRL_RESET 32'h0000_0000
`define FS_ST_ENABLES_HI 31
`define FS_ST_ENABLES_LO 24
`define FS_ST_LOOP 23
`define FS_ST_JADDR_HI 22
`define FS_ST_JADDR_LO 17
`define FS_ST_LIMIT_HI 16
`define FS_ST_LIMIT_LO 11
`define FS_ST_FADDR_HI 10
`define FS_ST_FADDR_LO 5
`define FS_ST_NEXT_HI 4
`define FS_ST_NEXT_LO 0
`define FS_CW_DP_HI 31
`define FS_CW_DP_LO 14
`define FS_CW_BUSWR 13
`define FS_CW_A_HI 12
`define FS_CW_A_LO 9
`define FS_CW_B_HI 8
`define FS_CW_B_LO 5
`define FS_CW_ADDR_HI 4
`define FS_CW_ADDR_LO 1
`define FS_CW_EOB 0
`endif

// ### filter_seq_pkg.sv
// Types of the filter microsequencer
package filter_seq_pkg;
    typedef enum logic [1:0] {seq_idle, seq_fetch, seq_exec} seq_phase_t;
    typedef enum logic [0:0] {cs_ram0, cs_ram1} cs_sel_t;
endpackage : filter_seq_pkg

// ### filter_seq_ram.sv
// Single-port-write, registered-read word memory
`timescale 1ns/1ns
`default_nettype none
module filter_seq_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk)
    begin
        rdata <= mem[raddr];
    end
endmodule : filter_seq_ram
`default_nettype wire
